//--- hdl/host_bus_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the host bus slave port.
// Assumes: A 50 MHz clock; Avalon-MM word addressing for the register window.
// Notes:   Definitions only.
// Contract
// - High address bits decode memory only, never I/O.
// - SA0 and byte-high enable pick lanes or 16-bit.
// - I/O enable: low-active AEN, or port bit high.
// - Retrace interrupt enabled by bit 5, cleared via bit 4.
// - Interrupt high in ISA mode, low in channel mode.
// - ROM enable low for C0000-C7FFF when enabled.
// - Sub-range to C67FF only when window bit zero.
// - Write to port 46E8 pulses ROM enable strobe.
// - Channel mode: ROM pin is card selected feedback.
// - Wide-transfer acknowledge for video memory; channel also I/O.
// - Ready drops only for video memory wait states.
// - Buffer direction low only on addressed reads.
// - Direction pins may carry CRT sync instead.
// - Memory read pin: read strobe or memory/I/O type.
// - Memory write pin: write strobe or status line.
`ifndef HOST_BUS_MAP_SVH
`define HOST_BUS_MAP_SVH

`define REG_CTRL        2'h0
`define REG_VRETRACE    2'h1
`define REG_STATUS      2'h2

`define CTRL_ROM_ENABLE 0
`define CTRL_ROM_MAP    1
`define CTRL_SYNC_SEL   2
`define CTRL_RESET      8'h_02

`define VRE_CLEAR_BIT   4
`define VRE_ENABLE_BIT  5
`define VRE_RESET       8'h_00

`define STAT_IRQ        0
`define STAT_MODE       1
`define STAT_WAIT       2
`define STAT_ACTIVE     3

`define VIDEO_LO        20'h_A_0000
`define VIDEO_HI        20'h_B_FFFF
`define ROM_LO          20'h_C_0000
`define ROM_HI          20'h_C_7FFF
`define ROM_SUB_LO      20'h_C_6000
`define ROM_SUB_HI      20'h_C_67FF
`define IO_LO           20'h_0_03B0
`define IO_HI           20'h_0_03DF
`define IO_ROM_PAGE     20'h_0_46E8

`define CLK_PERIOD_NS   20
`define WAIT_TIME_NS    60
`define WAIT_CYCLES     ((`WAIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hdl/host_bus_pkg.sv
// Purpose: Types and shared decode helpers of the host bus slave port.
// Assumes: Nothing beyond the map header.
// Notes:   Window compare is used for every range decode; port 46E8 is matched by an equality compare.
package host_bus_pkg;

	typedef enum logic
	{
		MODE_ISA     = 1'b0,
		MODE_CHANNEL = 1'b1
	} bus_mode_e;

	function automatic logic in_window(input logic [19:0] addr,
		input logic [19:0] lo, input logic [19:0] hi);
		in_window = (addr >= lo) && (addr <= hi);
	endfunction

endpackage

//--- hdl/input_sync.sv
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ns
module input_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					meta[g]   <= 1'b1;
					sync_o[g] <= 1'b1;
				end
				else
				begin
					meta[g]   <= pin_i[g];
					sync_o[g] <= meta[g];
				end
			end
		end
	endgenerate
endmodule // input_sync

//--- hdl/wait_timer.sv
// Purpose: Counts the wait states inserted into a video memory access.
// Assumes: start_i is a one-cycle pulse.
// Notes:   busy_o is high for CYCLES clocks after the start pulse.
`timescale 1ns/1ns
module wait_timer
#(
	parameter logic [3:0] CYCLES = 4'h_3
)
(
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic start_i,
	output logic      busy_o
);
	logic [3:0] count;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			count <= 4'h_0;
		else if (start_i)
			count <= CYCLES;
		else if (count != 4'h_0)
			count <= count - 4'h_1;
	end

	assign busy_o = (count != 4'h_0);
endmodule // wait_timer

//--- hdl/host_bus_slave.sv
// Purpose: Host system bus slave port: decode, ROM enable, ready, buffers, interrupt.
// Assumes: All host pins are asynchronous to clk_i and are synchronised first.
// Notes:   Registers are reached over Avalon-MM with waitrequest.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`include "host_bus_map.svh"
module host_bus_slave
	import host_bus_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [1:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        bus_mode_strap_i,
	input  wire logic [2:0]  la_i,
	input  wire logic [16:0] sa_i,
	input  wire logic        sbhe_n_i,
	input  wire logic        memory_decode_enable_i,
	input  wire logic        io_decode_enable_i,
	input  wire logic        slot_setup_select_i,
	input  wire logic        refresh_n_i,
	input  wire logic        memr_n_i,
	input  wire logic        memw_n_i,
	input  wire logic        ior_n_i,
	input  wire logic        iow_n_i,
	input  wire logic        vertical_display_end_i,
	input  wire logic        crt_hsync_i,
	input  wire logic        crt_vsync_i,
	output logic             irq_o,
	output logic             bios_rom_enable_n_o,
	output logic             card_wide_transfer_ack_n_o,
	output logic             channel_ready_o,
	output logic             upper_buffer_direction_o,
	output logic             lower_buffer_direction_o,
	output logic             access_valid_o,
	output logic             access_write_o,
	output logic             access_is_mem_o,
	output logic [19:0]      access_addr_o,
	output logic             lane_upper_o,
	output logic             lane_lower_o
);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	localparam int PINS = 32;

	logic [PINS-1:0] pin_raw;
	logic [PINS-1:0] pin_s;
	logic [PINS-1:0] pin_rst;

	assign pin_raw = {bus_mode_strap_i, la_i, sa_i, sbhe_n_i,
		memory_decode_enable_i, io_decode_enable_i, slot_setup_select_i,
		refresh_n_i, memr_n_i, memw_n_i, ior_n_i, iow_n_i, 2'b11};
	assign pin_rst = {PINS{1'b1}};

	input_sync #(
		.WIDTH     (PINS)
	) u_sync (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.pin_i     (pin_raw),
		.rst_val_i (pin_rst),
		.sync_o    (pin_s)
	);

	wire        strap_s    = pin_s[31];
	wire [2:0]  la_s       = pin_s[30:28];
	wire [16:0] sa_s       = pin_s[27:11];
	wire        sbhe_n_s   = pin_s[10];
	wire        mem_en_s   = pin_s[9];
	wire        io_en_s    = pin_s[8];
	wire        ale_s      = pin_s[7];
	wire        refresh_n_s = pin_s[6];
	wire        memr_n_s   = pin_s[5];
	wire        memw_n_s   = pin_s[4];
	wire        ior_n_s    = pin_s[3];
	wire        iow_n_s    = pin_s[2];

	// ----------------------------------------------------------------
	// Bus mode capture
	// ----------------------------------------------------------------
	bus_mode_e bus_mode;
	logic      mode_taken;
	logic [1:0] strap_settle;

	// The strap is taken once, at the third clock after release, when the
	// synchroniser shows the pin and no longer its reset value, and is held.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bus_mode     <= MODE_ISA;
			mode_taken   <= 1'b0;
			strap_settle <= 2'b00;
		end
		else
		begin
			strap_settle <= {strap_settle[0], 1'b1};
			if (strap_settle[1] && !mode_taken)
			begin
				bus_mode   <= bus_mode_e'(strap_s);
				mode_taken <= 1'b1;
			end
		end
	end

	wire is_isa = (bus_mode == MODE_ISA);

	// ----------------------------------------------------------------
	// Address latch
	// ----------------------------------------------------------------
	logic [2:0] la_hold;

	// In ISA mode the upper lines follow while ALE is high.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			la_hold <= 3'h_0;
		else if (!is_isa || ale_s)
			la_hold <= la_s;
	end

	// ----------------------------------------------------------------
	// Cycle type decode
	// ----------------------------------------------------------------
	wire cmd_active   = !iow_n_s;
	wire chan_is_mem  = memr_n_s;
	wire chan_rd      = cmd_active && !ior_n_s;
	wire chan_wr      = cmd_active && !memw_n_s;

	wire mem_rd = is_isa ? !memr_n_s : (chan_rd && chan_is_mem);
	wire mem_wr = is_isa ? !memw_n_s : (chan_wr && chan_is_mem);
	wire io_rd  = is_isa ? !ior_n_s  : (chan_rd && !chan_is_mem);
	wire io_wr  = is_isa ? !iow_n_s  : (chan_wr && !chan_is_mem);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire [19:0] mem_addr = {la_hold, sa_s};
	wire [19:0] io_addr  = {4'h_0, sa_s[15:0]};

	wire chan_enable = io_en_s;
	wire io_allowed  = is_isa ? !io_en_s : chan_enable;
	wire mem_allowed = mem_en_s && refresh_n_s
		&& (is_isa || chan_enable);

	wire video_hit = mem_allowed
		&& in_window(mem_addr, `VIDEO_LO, `VIDEO_HI);
	wire rom_sub   = in_window(mem_addr, `ROM_SUB_LO, `ROM_SUB_HI);
	wire page_port = io_allowed && (io_addr == `IO_ROM_PAGE);
	wire io_hit    = io_allowed
		&& (in_window(io_addr, `IO_LO, `IO_HI) || page_port);

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [7:0] ctrl;
	logic [7:0] vretrace;
	logic       irq_pending;

	wire rom_enable = ctrl[`CTRL_ROM_ENABLE];
	wire rom_map    = ctrl[`CTRL_ROM_MAP];
	wire sync_sel   = ctrl[`CTRL_SYNC_SEL];

	wire rom_hit = mem_allowed && rom_enable
		&& in_window(mem_addr, `ROM_LO, `ROM_HI)
		&& !(rom_sub && rom_map);

	wire bus_req    = avs_read_i || avs_write_i;
	wire bus_accept = bus_req && !avs_waitrequest_o;
	wire wr_lane0   = bus_accept && avs_write_i && avs_byteenable_i[0];
	wire wr_ctrl    = wr_lane0 && (avs_address_i == `REG_CTRL);
	wire wr_vre     = wr_lane0 && (avs_address_i == `REG_VRETRACE);

	wire irq_clear = wr_vre && !avs_writedata_i[`VRE_CLEAR_BIT];
	wire irq_set   = vertical_display_end_i && vretrace[`VRE_ENABLE_BIT];

	logic [31:0] read_value;
	logic        wait_busy;
	logic        cycle_active;

	always_comb
	begin
		read_value = 32'h_0000_0000;
		if (avs_address_i == `REG_CTRL)
			read_value[7:0] = ctrl;
		else if (avs_address_i == `REG_VRETRACE)
			read_value[7:0] = vretrace;
		else if (avs_address_i == `REG_STATUS)
		begin
			read_value[`STAT_IRQ]    = irq_pending;
			read_value[`STAT_MODE]   = bus_mode;
			read_value[`STAT_WAIT]   = wait_busy;
			read_value[`STAT_ACTIVE] = cycle_active;
		end
	end

	// One wait cycle per request; the answer comes on the second edge.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h_0000_0000;
		end
		else
		begin
			avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
			if (bus_req && avs_waitrequest_o)
				avs_readdata_o <= read_value;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctrl     <= `CTRL_RESET;
			vretrace <= `VRE_RESET;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= avs_writedata_i[7:0];
			if (wr_vre)
				vretrace <= avs_writedata_i[7:0];
		end
	end

	// A retrace event in the clearing cycle keeps the flag set.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_pending <= 1'b0;
		else if (irq_set)
			irq_pending <= 1'b1;
		else if (irq_clear)
			irq_pending <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Wait state timing
	// ----------------------------------------------------------------
	logic video_cycle_q;

	wire video_cycle = video_hit && (mem_rd || mem_wr);
	wire wait_start  = video_cycle && !video_cycle_q;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			video_cycle_q <= 1'b0;
		else
			video_cycle_q <= video_cycle;
	end

	wait_timer #(
		.CYCLES   (4'(`WAIT_CYCLES))
	) u_wait (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.start_i  (wait_start),
		.busy_o   (wait_busy)
	);

	// ----------------------------------------------------------------
	// Output decode
	// ----------------------------------------------------------------
	wire card_selected = chan_is_mem ? video_hit : io_hit;
	wire rom_strobe    = (rom_hit && (mem_rd || mem_wr))
		|| (io_wr && page_port);
	wire next_rom_n    = is_isa ? !rom_strobe
		: !card_selected;

	wire wide_ack = video_hit
		|| (!is_isa && !chan_is_mem && io_hit);
	wire next_ready = !(wait_busy || wait_start);

	wire read_hit  = (mem_rd && video_hit) || (io_rd && io_hit);
	wire next_upper = sync_sel ? crt_hsync_i : !read_hit;
	wire next_lower = sync_sel ? crt_vsync_i : !read_hit;

	wire next_irq = is_isa ? irq_pending : !irq_pending;

	wire next_valid = (video_cycle || (io_hit && (io_rd || io_wr)));
	wire next_write = mem_wr || io_wr;
	wire [19:0] next_addr = video_cycle ? mem_addr : io_addr;

	assign cycle_active = next_valid;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_o                      <= 1'b0;
			bios_rom_enable_n_o        <= 1'b1;
			card_wide_transfer_ack_n_o <= 1'b1;
			channel_ready_o            <= 1'b1;
			upper_buffer_direction_o   <= 1'b1;
			lower_buffer_direction_o   <= 1'b1;
		end
		else
		begin
			irq_o                      <= next_irq;
			bios_rom_enable_n_o        <= next_rom_n;
			card_wide_transfer_ack_n_o <= !wide_ack;
			channel_ready_o            <= next_ready;
			upper_buffer_direction_o   <= next_upper;
			lower_buffer_direction_o   <= next_lower;
		end
	end

	// Byte lanes: SA0 low with byte-high low is a 16-bit transfer.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			access_valid_o  <= 1'b0;
			access_write_o  <= 1'b0;
			access_is_mem_o <= 1'b0;
			access_addr_o   <= 20'h_0_0000;
			lane_upper_o    <= 1'b0;
			lane_lower_o    <= 1'b0;
		end
		else
		begin
			access_valid_o  <= next_valid;
			access_write_o  <= next_write;
			access_is_mem_o <= video_cycle;
			access_addr_o   <= next_addr;
			lane_upper_o    <= !sbhe_n_s;
			lane_lower_o    <= !sa_s[0];
		end
	end

endmodule // host_bus_slave

//--- tb/ext_decode_model.sv
// Purpose: External decode logic that drives the memory enable pin.
// Assumes: Upper address, refresh and wide address enable come from the host.
// Notes:   Behavioural and combinational.
`timescale 1ns/1ns
module ext_decode_model
(
	input  wire logic       mode_i,
	input  wire logic [3:0] la_top_i,
	input  wire logic       refresh_n_i,
	input  wire logic       wide_address_enable_i,
	output logic            memory_decode_enable_o
);
	// In ISA mode refresh cycles must never look like memory accesses; in channel mode the enable follows wide address enable.
	assign memory_decode_enable_o = (la_top_i == 4'h_0)
		&& (mode_i ? wide_address_enable_i : refresh_n_i);
endmodule // ext_decode_model

//--- tb/host_bus_slave_asserts.sv
// Purpose: Port checker of the host bus slave.
// Assumes: Bus mode strap changes only under reset.
// Notes:   Bound to every host_bus_slave instance.
`timescale 1ns/1ns
`include "host_bus_map.svh"
module host_bus_slave_asserts
(
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic        avs_waitrequest_o,
	input wire logic        bus_mode_strap_i,
	input wire logic [2:0]  la_i,
	input wire logic [16:0] sa_i,
	input wire logic        sbhe_n_i,
	input wire logic        bios_rom_enable_n_o,
	input wire logic        card_wide_transfer_ack_n_o,
	input wire logic        channel_ready_o,
	input wire logic        lower_buffer_direction_o,
	input wire logic        access_valid_o,
	input wire logic        access_write_o,
	input wire logic        access_is_mem_o,
	input wire logic [19:0] access_addr_o,
	input wire logic        lane_upper_o,
	input wire logic        lane_lower_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	wire mem_hit = access_valid_o && access_is_mem_o;
	wire video   = access_addr_o >= `VIDEO_LO && access_addr_o <= `VIDEO_HI;
	wire rom     = access_addr_o >= `ROM_LO && access_addr_o <= `ROM_HI;
	sequence s_wait_run;
		(!channel_ready_o)[*4] ##1 channel_ready_o;
	endsequence
	sequence s_one_wait;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	a_ready_len: assert property ($fell(channel_ready_o) |-> s_wait_run)
		else $error("ready low for wrong length");
	a_ready_mem: assert property ($fell(channel_ready_o) |-> mem_hit && video)
		else $error("ready dropped outside video access");
	a_ready_io: assert property (access_valid_o && !access_is_mem_o |-> channel_ready_o)
		else $error("ready dropped on io cycle");
	a_dir_read: assert property (!lower_buffer_direction_o |-> access_valid_o && !access_write_o)
		else $error("buffer turned outside read");
	a_lane_pick: assert property (access_valid_o |-> lane_lower_o == !$past(sa_i[0], 3)
		&& lane_upper_o == !$past(sbhe_n_i, 3))
		else $error("lane select wrong");
	a_mem_addr: assert property (mem_hit |-> access_addr_o == {$past(la_i, 4), $past(sa_i, 3)})
		else $error("memory address wrong");
	a_wide_video: assert property (mem_hit && video |-> !card_wide_transfer_ack_n_o)
		else $error("wide ack missing");
	a_rom_window: assert property (!bus_mode_strap_i && mem_hit && !rom |-> bios_rom_enable_n_o)
		else $error("rom enable outside window");
	a_avs_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_one_wait)
		else $error("register answer timing wrong");
endmodule // host_bus_slave_asserts
bind host_bus_slave host_bus_slave_asserts i_host_bus_slave_asserts (.*);

//--- tb/tb_display_host_bus_slave_port.sv
// Purpose: Self-checking bench of the host bus slave.
// Assumes: Pin outputs follow three edges after a pin change (upper address is latched once more).
// Notes:   Scenarios are tasks; expectations come from the decode windows.
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb_display_host_bus_slave_port;
	logic        clk_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic        bus_mode_strap_i, sbhe_n_i, memory_decode_enable_i, io_decode_enable_i;
	logic        slot_setup_select_i, refresh_n_i, memr_n_i, memw_n_i, ior_n_i, iow_n_i;
	logic        vertical_display_end_i, crt_hsync_i, crt_vsync_i, irq_o;
	logic        bios_rom_enable_n_o, card_wide_transfer_ack_n_o, channel_ready_o;
	logic        upper_buffer_direction_o, lower_buffer_direction_o, access_valid_o;
	logic        access_write_o, access_is_mem_o, lane_upper_o, lane_lower_o;
	logic [1:0]  avs_address_i;
	logic [2:0]  la_i;
	logic [3:0]  avs_byteenable_i;
	logic [16:0] sa_i;
	logic [19:0] access_addr_o;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	int          error_cnt, comparisons;
	host_bus_slave i_host_bus_slave (.*);
	ext_decode_model i_ext_decode_model (.mode_i(bus_mode_strap_i), .la_top_i(4'h_0),
		.refresh_n_i(refresh_n_i), .wide_address_enable_i(1'b1),
		.memory_decode_enable_o(memory_decode_enable_i));
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 20);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 20)
		begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic rst(input logic mode);
		bus_mode_strap_i <= mode;
		arst_n_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask
	// Drives one cycle in the meaning of the bus mode given by ch, then waits out the sync path.
	task automatic cyc(input logic ch, input logic mem, input logic wr,
		input logic [19:0] a, input logic sb);
		la_i <= a[19:17];
		sa_i <= a[16:0];
		sbhe_n_i <= sb;
		memr_n_i <= ch ? mem : !(mem && !wr);
		memw_n_i <= ch ? !wr : !(mem && wr);
		ior_n_i <= ch ? wr : !(!mem && !wr);
		iow_n_i <= ch ? 1'b0 : !(!mem && wr);
		repeat (5) @(posedge clk_i);
	endtask
	task automatic idle;
		{memr_n_i, memw_n_i, ior_n_i, iow_n_i} <= 4'h_F;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic t_regs;
		av(0, `REG_CTRL, 0);
		`CHK("ctrl", 32'h_0000_0002, q)
		av(0, `REG_VRETRACE, 0);
		`CHK("vretrace", 32'h_0000_0000, q)
		av(1, 2'h3, 32'h_FFFF_FFFF);
		av(0, 2'h3, 0);
		`CHK("unmapped", 32'h_0000_0000, q)
		av(0, `REG_STATUS, 0);
		`CHK("status", 32'h_0000_0000, q)
		$display("test regs done");
	endtask
	task automatic t_video;
		cyc(0, 1, 0, 20'h_A_0000, 0);
		`CHK("wide_n", 1'b0, card_wide_transfer_ack_n_o)
		`CHK("ready", 1'b0, channel_ready_o)
		`CHK("dirs", 2'b00, {upper_buffer_direction_o, lower_buffer_direction_o})
		`CHK("lanes", 2'b11, {lane_upper_o, lane_lower_o})
		`CHK("addr", 20'h_A_0000, access_addr_o)
		`CHK("is_mem", 1'b1, access_is_mem_o)
		idle();
		cyc(0, 1, 1, 20'h_B_0001, 0);
		`CHK("lanes", 2'b10, {lane_upper_o, lane_lower_o})
		`CHK("dirs", 2'b11, {upper_buffer_direction_o, lower_buffer_direction_o})
		idle();
		refresh_n_i <= 1'b0;
		cyc(0, 1, 0, 20'h_A_0000, 0);
		`CHK("valid", 1'b0, access_valid_o)
		idle();
		refresh_n_i <= 1'b1;
		$display("test video done");
	endtask
	task automatic t_io;
		cyc(0, 0, 0, 20'h_E_03C0, 1);
		`CHK("valid", 1'b1, access_valid_o)
		`CHK("io_addr", 20'h_0_03C0, access_addr_o)
		`CHK("ready", 1'b1, channel_ready_o)
		`CHK("wide_n", 1'b1, card_wide_transfer_ack_n_o)
		`CHK("dirs", 2'b00, {upper_buffer_direction_o, lower_buffer_direction_o})
		idle();
		io_decode_enable_i <= 1'b1;
		cyc(0, 0, 0, 20'h_0_03C0, 1);
		`CHK("valid", 1'b0, access_valid_o)
		idle();
		io_decode_enable_i <= 1'b0;
		$display("test io done");
	endtask
	task automatic rom_at(input logic mem, input logic [19:0] a, input logic e);
		cyc(0, mem, !mem, a, 1);
		`CHK("rom_n", e, bios_rom_enable_n_o)
		`CHK("ready", 1'b1, channel_ready_o)
		idle();
	endtask
	task automatic t_rom;
		av(1, `REG_CTRL, 32'h_0000_0001);
		rom_at(1, `ROM_SUB_LO, 0);
		av(1, `REG_CTRL, 32'h_0000_0003);
		rom_at(1, `ROM_SUB_HI, 1);
		rom_at(1, `ROM_LO, 0);
		rom_at(1, `ROM_HI, 0);
		rom_at(1, 20'h_C_8000, 1);
		rom_at(0, `IO_ROM_PAGE, 0);
		av(1, `REG_CTRL, 32'h_0000_0002);
		rom_at(1, `ROM_LO, 1);
		$display("test rom done");
	endtask
	task automatic t_sync;
		crt_vsync_i <= 1'b1;
		av(1, `REG_CTRL, 32'h_0000_0006);
		cyc(0, 1, 0, 20'h_A_0000, 0);
		`CHK("sync_dirs", 2'b01, {upper_buffer_direction_o, lower_buffer_direction_o})
		idle();
		av(1, `REG_CTRL, 32'h_0000_0002);
		crt_vsync_i <= 1'b0;
		$display("test sync done");
	endtask
	task automatic vde(input logic [31:0] v, input logic e);
		av(1, `REG_VRETRACE, v);
		vertical_display_end_i <= 1'b1;
		@(posedge clk_i);
		vertical_display_end_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("irq", e, irq_o)
	endtask
	task automatic t_irq;
		vde(32'h_0000_0010, 0);
		vde(32'h_0000_0030, 1);
		av(0, `REG_STATUS, 0);
		`CHK("pending", 1'b1, q[`STAT_IRQ])
		av(1, `REG_VRETRACE, 32'h_0000_0020);
		repeat (2) @(posedge clk_i);
		`CHK("irq", 1'b0, irq_o)
		$display("test irq done");
	endtask
	task automatic t_chan;
		rst(1);
		io_decode_enable_i <= 1'b1;
		`CHK("irq", 1'b1, irq_o)
		av(0, `REG_STATUS, 0);
		`CHK("mode", 1'b1, q[`STAT_MODE])
		cyc(1, 0, 0, 20'h_0_03C0, 0);
		`CHK("wide_n", 1'b0, card_wide_transfer_ack_n_o)
		`CHK("rom_n", 1'b0, bios_rom_enable_n_o)
		`CHK("dirs", 2'b00, {upper_buffer_direction_o, lower_buffer_direction_o})
		idle();
		cyc(1, 1, 1, 20'h_A_0000, 0);
		`CHK("ready", 1'b0, channel_ready_o)
		`CHK("write", 1'b1, access_write_o)
		idle();
		io_decode_enable_i <= 1'b0;
		cyc(1, 1, 0, 20'h_A_0000, 0);
		`CHK("valid", 1'b0, access_valid_o)
		idle();
		$display("test channel done");
	endtask
	initial
	begin
		error_cnt = 0;
		comparisons = 0;
		{avs_read_i, avs_write_i, vertical_display_end_i, io_decode_enable_i} = 4'h_0;
		{memr_n_i, memw_n_i, ior_n_i, iow_n_i, refresh_n_i, sbhe_n_i} = 6'h_3F;
		{crt_hsync_i, crt_vsync_i, bus_mode_strap_i} = 3'h_0;
		slot_setup_select_i = 1'b1;
		avs_address_i = 2'h0;
		avs_writedata_i = 32'h_0000_0000;
		avs_byteenable_i = 4'h_F;
		la_i = 3'h0;
		sa_i = 17'h_0_0000;
		arst_n_i = 1'b0;
		@(posedge clk_i);
		rst(0);
		t_regs();
		t_video();
		t_io();
		t_rom();
		t_sync();
		t_irq();
		t_chan();
		summarize();
	end
endmodule // tb_display_host_bus_slave_port
